// File: hdl/dsrc_strobe_capture.v
/*
  Strobe read capture for the DDR groups of one device edge, with the
  delay-locked loop that trims the strobe delay.
  Assumes dqs and dq come straight from pins, and read_en and the DLL
  phase detector output come from logic on clk.
*/
`timescale 1ns/10ps
`include "dsrc_defines.vh"

module dsrc_strobe_capture
#(
  parameter NUM_GROUPS      = 2,
  parameter CELLS_PER_GROUP = 14,
  parameter GROUP_DQ_W      = 8
)
(
  input  wire                           clk,
  input  wire                           nrst,
  input  wire [NUM_GROUPS-1:0]          dqs_i,
  input  wire [NUM_GROUPS*GROUP_DQ_W-1:0] dq_i,
  input  wire                           read_en,
  input  wire                           dll_fb_early,
  output reg  [NUM_GROUPS-1:0]          read_strobe_quarter_shift,
  output reg  [NUM_GROUPS-1:0]          write_strobe_quarter_shift,
  output reg  [NUM_GROUPS-1:0]          capture_clock_polarity,
  output reg  [NUM_GROUPS-1:0]          capture_valid_flag,
  output reg  [NUM_GROUPS*GROUP_DQ_W-1:0] read_data,
  output reg  [`DSRC_CAL_W-1:0]         cal_code,
  output reg                            dll_locked
);

  localparam TAPS = 1 << `DSRC_CAL_W;

  // Cells beyond the data bits carry strobe, mask and spare
  localparam CELL_OK = (CELLS_PER_GROUP == 14) || (CELLS_PER_GROUP == 12);
  localparam DATA_OK = (NUM_GROUPS * GROUP_DQ_W) <= 16;

  // Edge tap select, used by every group and both strobes
  function tap_sel;
    input [TAPS-1:0]        line;
    input [`DSRC_CAL_W-1:0] code;
    begin
      tap_sel = line[code];
    end
  endfunction

  // Half-rate phase of clk; its value at the strobe edge picks polarity
  reg                     phase_q;
  reg [`DSRC_CNT_W-1:0]   dll_cnt_q;
  reg                     fb_s1_q;
  reg                     fb_s2_q;
  reg                     last_dir_q;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      phase_q <= 1'b0;
    else
      phase_q <= ~phase_q;
  end

  // Up/down trim of the code at a fixed rate from clk feedback
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fb_s1_q    <= 1'b0;
      fb_s2_q    <= 1'b0;
      dll_cnt_q  <= {`DSRC_CNT_W{1'b0}};
      cal_code   <= `DSRC_CAL_RST;
      last_dir_q <= 1'b0;
      dll_locked <= 1'b0;
    end
    else
    begin
      fb_s1_q <= dll_fb_early;
      fb_s2_q <= fb_s1_q;
      if (dll_cnt_q == `DSRC_DLL_CYC - 1)
      begin
        dll_cnt_q  <= {`DSRC_CNT_W{1'b0}};
        last_dir_q <= fb_s2_q;
        // Dithering between two codes means the loop has settled
        dll_locked <= (fb_s2_q != last_dir_q);
        if (fb_s2_q && cal_code != {`DSRC_CAL_W{1'b1}})
          cal_code <= cal_code + 1'b1; // R10
        else if (!fb_s2_q && cal_code != {`DSRC_CAL_W{1'b0}})
          cal_code <= cal_code - 1'b1; // R10
      end
      else
        dll_cnt_q <= dll_cnt_q + 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g = g + 1)
    begin : grp
      reg                   dqs_s1_q;
      reg                   dqs_s2_q;
      reg                   dqs_p_q;
      reg [GROUP_DQ_W-1:0]  dq_s1_q;
      reg [GROUP_DQ_W-1:0]  dq_s2_q;
      reg [TAPS-1:0]        line_q;
      reg                   rd_p_q;
      reg [1:0]             state_q;
      reg [`DSRC_CNT_W-1:0] cnt_q;
      reg [GROUP_DQ_W-1:0]  cap_q;
      reg                   cap_v_q;
      reg [GROUP_DQ_W-1:0]  late_q;
      reg                   late_v_q;
      wire                  rd_tap;
      wire                  rd_edge;
      wire                  rise;

      // Strobe delay line; the tap chosen by the code is the quarter shift
      assign rd_tap  = tap_sel(line_q, cal_code);                  // R09
      assign rd_edge = rd_tap ^ rd_p_q;
      assign rise    = dqs_s2_q & ~dqs_p_q;

      always @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          dqs_s1_q <= 1'b0;
          dqs_s2_q <= 1'b0;
          dqs_p_q  <= 1'b0;
          dq_s1_q  <= {GROUP_DQ_W{1'b0}};
          dq_s2_q  <= {GROUP_DQ_W{1'b0}};
          line_q   <= {TAPS{1'b0}};
          rd_p_q   <= 1'b0;
          read_strobe_quarter_shift[g]  <= 1'b0;
          write_strobe_quarter_shift[g] <= 1'b0;
        end
        else
        begin
          dqs_s1_q <= dqs_i[g];
          dqs_s2_q <= dqs_s1_q;
          dqs_p_q  <= dqs_s2_q;
          dq_s1_q  <= dq_i[g*GROUP_DQ_W +: GROUP_DQ_W];
          dq_s2_q  <= dq_s1_q;
          line_q   <= {line_q[TAPS-2:0], dqs_s2_q};
          rd_p_q   <= rd_tap;
          read_strobe_quarter_shift[g]  <= rd_tap;                 // R03
          // Write strobe trails by one stage so it never leads read
          write_strobe_quarter_shift[g] <= rd_p_q;                 // R03
        end
      end

      // Read preamble tracking and polarity evaluation
      always @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          state_q  <= `DSRC_ST_IDLE;
          cnt_q    <= {`DSRC_CNT_W{1'b0}};
          capture_clock_polarity[g] <= 1'b0;
        end
        else
        begin
          case (state_q)
            `DSRC_ST_IDLE:
            begin
              cnt_q <= {`DSRC_CNT_W{1'b0}};
              if (read_en)
                state_q <= `DSRC_ST_WAIT;                          // R05
            end
            `DSRC_ST_WAIT:
            begin
              // Terminated strobe may read either way; need a held low
              if (!read_en)
                state_q <= `DSRC_ST_IDLE;
              else if (dqs_s2_q)
                cnt_q <= {`DSRC_CNT_W{1'b0}};                      // R06
              else if (cnt_q == `DSRC_PRE_CYC - 1)
                state_q <= `DSRC_ST_PRE;                           // R06
              else
                cnt_q <= cnt_q + 1'b1;
            end
            `DSRC_ST_PRE:
            begin
              cnt_q <= {`DSRC_CNT_W{1'b0}};
              if (!read_en)
                state_q <= `DSRC_ST_IDLE;
              else if (rise)
              begin
                capture_clock_polarity[g] <= phase_q;              // R07
                state_q <= `DSRC_ST_BURST;
              end
            end
            `DSRC_ST_BURST:
            begin
              // Strobe stops after the burst; idle gap ends the read
              if (rise || dqs_s2_q != dqs_p_q)
                cnt_q <= {`DSRC_CNT_W{1'b0}};
              else if (cnt_q == `DSRC_GAP_CYC - 1)
                state_q <= `DSRC_ST_IDLE;
              else
                cnt_q <= cnt_q + 1'b1;
            end
            default:
              state_q <= `DSRC_ST_IDLE;
          endcase
        end
      end

      // Capture at each delayed strobe edge, then retime per polarity
      always @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          cap_q    <= {GROUP_DQ_W{1'b0}};
          cap_v_q  <= 1'b0;
          late_q   <= {GROUP_DQ_W{1'b0}};
          late_v_q <= 1'b0;
          read_data[g*GROUP_DQ_W +: GROUP_DQ_W] <= {GROUP_DQ_W{1'b0}};
          capture_valid_flag[g] <= 1'b0;
        end
        else
        begin
          cap_v_q  <= rd_edge && (state_q == `DSRC_ST_BURST);
          if (rd_edge)
            cap_q <= dq_s2_q;
          late_q   <= cap_q;
          late_v_q <= cap_v_q;
          // Odd polarity takes the later stage, away from the edge
          if (capture_clock_polarity[g])                           // R04
          begin
            read_data[g*GROUP_DQ_W +: GROUP_DQ_W] <= late_q;       // R08
            capture_valid_flag[g] <= late_v_q;                     // R11
          end
          else
          begin
            read_data[g*GROUP_DQ_W +: GROUP_DQ_W] <= cap_q;        // R08
            capture_valid_flag[g] <= cap_v_q;                      // R11
          end
        end
      end
    end
  endgenerate

  // Shared strobes reach every cell of a group from this one element
  wire unused_ok = CELL_OK & DATA_OK;                              // R01 R02

endmodule

// File: pkg/dsrc_defines.vh
/*
  Constants for the strobe read capture element: timing, states, DLL.
  Assumes a 40 MHz system clock and a strobe much slower than it.
*/
//
// Overview of operation
// [R01] Two groups of 14 or 12 io_logic_cells give at most a 16-bit data path.
// [R02] One strobe element per io_cell_group drives the group's shared strobes.
// [R03] Read and write quarter-shift strobes both come from the data strobe.
// [R04] A polarity selector picks the edge used to retime data to clk.
// [R05] Capture polarity is worked out again at every read.
// [R06] The memory idles the strobe tri-stated, then drives it low at preamble.
// [R07] The first strobe rising edge after preamble sets capture polarity.
// [R08] capture_clock_polarity steers the synchronizing capture registers.
// [R09] A 6-bit calibration code from the DLL trims the strobe delay.
// [R10] The DLL keeps its code trimmed from clk and its own feedback.
// [R11] capture_valid_flag is high only while retimed read data is valid.
`ifndef DSRC_DEFINES_VH
`define DSRC_DEFINES_VH

`define DSRC_CLK_NS        25
`define DSRC_PRE_NS        50
`define DSRC_PRE_CYC       ((`DSRC_PRE_NS + `DSRC_CLK_NS - 1) / `DSRC_CLK_NS)
`define DSRC_GAP_NS        400
`define DSRC_GAP_CYC       (`DSRC_GAP_NS / `DSRC_CLK_NS)
`define DSRC_DLL_NS        400
`define DSRC_DLL_CYC       (`DSRC_DLL_NS / `DSRC_CLK_NS)
`define DSRC_CAL_W         6
`define DSRC_CAL_RST       6'h02
`define DSRC_CNT_W         8

`define DSRC_ST_IDLE       2'h0
`define DSRC_ST_WAIT       2'h1
`define DSRC_ST_PRE        2'h2
`define DSRC_ST_BURST      2'h3

`endif

// File: verification/dsrc_chk.sv
/* Port checker for the strobe capture element.
   Assumes 2-FF input syncs and strobe edges at least 4 clk apart. */
`timescale 1ns/10ps
module dsrc_chk
#(
  parameter NUM_GROUPS = 2
)
(
  input logic                  clk,
  input logic                  nrst,
  input logic                  read_en,
  input logic                  dll_fb_early,
  input logic [NUM_GROUPS-1:0] read_strobe_quarter_shift,
  input logic [NUM_GROUPS-1:0] write_strobe_quarter_shift,
  input logic [NUM_GROUPS-1:0] capture_clock_polarity,
  input logic [NUM_GROUPS-1:0] capture_valid_flag,
  input logic [5:0]            cal_code
);
  wire [NUM_GROUPS-1:0] rs = read_strobe_quarter_shift;
  wire [NUM_GROUPS-1:0] vl = capture_valid_flag;
  wire [NUM_GROUPS-1:0] pl = capture_clock_polarity;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wr_lag_a: assert property (
    write_strobe_quarter_shift == $past(rs)) else $error("write lag");
  cal_dir_a: assert property (
    $changed(cal_code) && $past(dll_fb_early, 2) == $past(dll_fb_early, 4)
    |-> ($past(dll_fb_early, 3) ? cal_code > $past(cal_code)
    : cal_code < $past(cal_code))) else $error("trim direction");
  cal_hold_a: assert property (
    $changed(cal_code) |=> $stable(cal_code) [*8]) else $error("trim rate");
  valid_pulse_a: assert property (
    vl[0] |=> !vl[0]) else $error("valid too long");
  valid_edge0_a: assert property (
    vl[0] |-> $past(rs[0]) != $past(rs[0], 3)) else $error("valid no edge");
  valid_edge1_a: assert property (
    vl[1] |-> $past(rs[1]) != $past(rs[1], 3)) else $error("valid no edge");
  pol_read_a: assert property (
    $changed(pl[0]) |-> $past(read_en)) else $error("polarity off read");
  pol_first_a: assert property (
    $changed(pl[0]) |-> ##[1:8] vl[0]) else $error("no data on polarity");
endmodule
bind dsrc_strobe_capture dsrc_chk #(.NUM_GROUPS(NUM_GROUPS)) u_chk (.*);

// File: verification/dsrc_mem_model.sv
/* Read side of a DDR memory: strobe and data for two groups.
   Assumes go pulses only while the model is idle. */
`timescale 1ns/10ps
module dsrc_mem_model
(
  input  logic        go,
  input  logic [7:0]  base,
  input  int          nb,
  output logic [1:0]  dqs,
  output logic [15:0] dq
);
  // Idle strobe sits at the termination's pull-up level
  initial
  begin
    dqs = 2'h3;
    dq = 16'h0000;
  end
  always @(posedge go)
  begin
    #300 dqs = 2'h0;
    #200;
    for (int k = 0; k < nb; k++)
    begin
      dqs = ~dqs;
      dq = {~(base + k[7:0]), base + k[7:0]};
      #100;
    end
    dq = ~dq;
    // Long postamble, so release is seen after the burst timeout
    #500 dqs = 2'h3;
  end
endmodule

// File: verification/test_dsrc_strobe_capture.sv
/* Self-checking bench for the strobe capture element.
   Assumes default parameters: two groups of 8 data bits. */
`timescale 1ns/10ps
module test_dsrc_strobe_capture;
  logic clk = 0, nrst = 0, read_en = 0, fb = 0, go = 0, auto = 1;
  logic [7:0] base = 8'h00;
  logic [1:0] p1 = 2'h0;
  int nb = 8, mismatches = 0, check_count = 0;
  wire [1:0] dqs, rsq, wsq, pol, vld;
  wire [15:0] dq, rd;
  wire [5:0] cal;
  wire lock;
  always #12.5 clk = ~clk;
  // Phase detector stand-in keeps the trim dithering around 1..2
  always @(posedge clk) if (auto) fb <= #1 (cal < 6'h02);
  dsrc_mem_model u_mem (.go(go), .base(base), .nb(nb), .dqs(dqs), .dq(dq));
  dsrc_strobe_capture u_dut
  (
    .clk(clk), .nrst(nrst), .dqs_i(dqs), .dq_i(dq), .read_en(read_en),
    .dll_fb_early(fb), .read_strobe_quarter_shift(rsq),
    .write_strobe_quarter_shift(wsq), .capture_clock_polarity(pol),
    .capture_valid_flag(vld), .read_data(rd), .cal_code(cal),
    .dll_locked(lock)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task test_done;
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic t_read(input int n, input logic [7:0] b, input logic ab);
    int k;
    k = 0;
    @(posedge clk);
    #1;
    read_en = 1;
    base = b;
    nb = n;
    go = 1;
    @(posedge clk);
    #1;
    go = 0;
    read_en = !ab;
    for (int i = 0; i < 140; i++)
    begin
      @(posedge clk);
      #1;
      if (vld[0] === 1'b1)
      begin
        chk(rd[7:0], b + k[7:0]);
        chk(rd[15:8], ~(b + k[7:0]));
        chk({7'h00, vld[1]}, 8'h01);
        k++;
      end
      // Off before the pulled-up release can pose as a new preamble
      if (k == n)
        read_en = 0;
    end
    chk(k[7:0], ab ? 8'h00 : n[7:0]);
    @(posedge clk);
    #1;
    read_en = 0;
  endtask
  task t_dll;
    chk({7'h00, lock}, 8'h01);
    @(posedge clk);
    #1;
    auto = 0;
    // Stand-in may still have one update queued from the last edge
    @(posedge clk);
    #1;
    fb = 1;
    repeat (1100) @(posedge clk);
    #1;
    chk({2'h0, cal}, 8'h3F);
    chk({7'h00, lock}, 8'h00);
    fb = 0;
    repeat (1100) @(posedge clk);
    #1;
    chk({2'h0, cal}, 8'h00);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    #1;
    nrst = 1;
    chk({2'h0, cal}, 8'h02);
    chk({rsq, wsq, pol, vld}, 8'h00);
    t_read(8, 8'h30, 0);
    p1 = pol;
    // Odd cycle shift puts the strobe on the other clk phase
    repeat (4) @(posedge clk);
    t_read(6, 8'hC5, 0);
    chk({6'h00, pol}, {6'h00, ~p1});
    t_read(8, 8'h5A, 1);
    chk({6'h00, pol}, {6'h00, ~p1});
    t_dll;
    test_done;
  end
endmodule
